// ---- rfb_consts.svh ----
`ifndef RFB_CONSTS_SVH
`define RFB_CONSTS_SVH
`define RFB_CLK_MHZ       250
`define RFB_TICK_MS       50
`define RFB_TICK_CYCLES   (`RFB_TICK_MS * 1000 * `RFB_CLK_MHZ)
`define RFB_STEPS         12
`define RFB_LAST_STEP     4'hb
`define RFB_LAST_TICKS    3'h5
`define RFB_ACTIVE_TICKS  400
`endif

// ---- rfb_pkg.sv ----
package rfb_pkg;
   typedef enum logic {RFB_IDLE, RFB_FLASH} rfb_mode_t;
   typedef struct packed {
      logic left;
      logic right;
   } rfb_lamp_t;
endpackage : rfb_pkg

// ---- rfb_sequencer.sv ----
`timescale 1ns/10ps
`include "rfb_consts.svh"
module rfb_sequencer #(
   parameter int TICK_CYCLES = `RFB_TICK_CYCLES,
   parameter int CNT_W       = 24,
   parameter int PERIOD_W    = 16
) (
   input  wire logic                MCLK,          // System clock.
   input  wire logic                SRST,          // Synchronous reset, active high.
   input  wire logic                BUTTON,        // Pushbutton detection, level.
   input  wire logic                PASSIVE_EN,    // Passive detection in use.
   input  wire logic                PRESENT,       // Passive detector sees a pedestrian.
   input  wire logic                PEER_START,    // Start pulse from a peer unit.
   input  wire logic                PEER_STOP,     // Stop pulse from a peer unit.
   input  wire logic                NIGHT,         // Photocell reports night.
   input  wire logic [PERIOD_W-1:0] ACTIVE_TICKS,  // Active period in 50 ms ticks.
   output logic                     LAMP_LEFT,     // Left light drive.
   output logic                     LAMP_RIGHT,    // Right light drive.
   output logic                     DIM,           // Dimming control.
   output logic                     PILOT,         // Pilot light.
   output logic                     SYNC_START,    // Start pulse to peers.
   output logic                     SYNC_STOP      // Stop pulse to peers.
);
   typedef struct packed {
      rfb_pkg::rfb_mode_t  mode;
      logic [CNT_W-1:0]    tick_cnt;
      logic [3:0]          step;
      logic [2:0]          sub;
      logic [PERIOD_W-1:0] remain;
      rfb_pkg::rfb_lamp_t  lamp;
      logic                dim;
      logic                pilot;
      logic                sync_start;
      logic                sync_stop;
   } rfb_state_t;

   rfb_state_t st;
   rfb_state_t next_st;

   function automatic rfb_pkg::rfb_lamp_t step_lamp(input logic [3:0] s);
      rfb_pkg::rfb_lamp_t l;
      l = '0;
      case (s)
         4'h0, 4'h4: l.left = 1'b1;
         4'h2, 4'h6: l.right = 1'b1;
         4'h8: begin
            l.left  = 1'b1;
            l.right = 1'b1;
         end
         4'ha: l.right = 1'b1;
         default: l = '0;
      endcase
      return l;
   endfunction : step_lamp

   logic detect;
   logic tick;
   assign detect = BUTTON | (PASSIVE_EN & PRESENT);
   assign tick   = (st.tick_cnt == CNT_W'(TICK_CYCLES - 1));

   always_comb begin
      next_st            = st;
      next_st.sync_start = 1'b0;
      next_st.sync_stop  = 1'b0;
      next_st.dim        = NIGHT;
      case (st.mode)
         rfb_pkg::RFB_IDLE: begin
            next_st.lamp = '0;
            if (detect || PEER_START) begin
               next_st.mode       = rfb_pkg::RFB_FLASH;
               next_st.tick_cnt   = '0;
               next_st.step       = '0;
               next_st.sub        = '0;
               next_st.remain     = ACTIVE_TICKS;
               next_st.sync_start = ~PEER_START;
               next_st.lamp       = step_lamp(4'h0);
            end
         end
         rfb_pkg::RFB_FLASH: begin
            next_st.tick_cnt = tick ? '0 : st.tick_cnt + 1'b1;
            if (tick) begin
               if (st.remain != '0) next_st.remain = st.remain - 1'b1;
               if (st.step == `RFB_LAST_STEP && st.sub != `RFB_LAST_TICKS - 1'b1) begin
                  next_st.sub = st.sub + 1'b1;
               end else begin
                  next_st.sub  = '0;
                  next_st.step = (st.step == `RFB_LAST_STEP) ? 4'h0 : st.step + 1'b1;
               end
            end
            next_st.lamp = step_lamp(next_st.step);
            if (detect) next_st.remain = ACTIVE_TICKS;
            // A detection in the stop cycle keeps the unit flashing in either detection mode, unless PEER_STOP is high in the same cycle.
            if (PEER_STOP || (st.remain == '0 && !detect)) begin
               next_st.mode      = rfb_pkg::RFB_IDLE;
               next_st.lamp      = '0;
               next_st.sync_stop = ~PEER_STOP;
            end
         end
         default: next_st.mode = rfb_pkg::RFB_IDLE;
      endcase
      next_st.pilot = (next_st.mode == rfb_pkg::RFB_FLASH);
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         st      <= '0;
         st.mode <= rfb_pkg::RFB_IDLE;
      end else begin
         st <= next_st;
      end
   end

   assign LAMP_LEFT  = st.lamp.left;
   assign LAMP_RIGHT = st.lamp.right;
   assign DIM        = st.dim;
   assign PILOT      = st.pilot;
   assign SYNC_START = st.sync_start;
   assign SYNC_STOP  = st.sync_stop;

   a_idle_dark: assert property (@(posedge MCLK) disable iff (SRST)
      (st.mode == rfb_pkg::RFB_IDLE) |-> !LAMP_LEFT && !LAMP_RIGHT)
      else $error("Light on while idle.");
   a_start_cause: assert property (@(posedge MCLK) disable iff (SRST)
      $rose(PILOT) |-> $past(detect) || $past(PEER_START))
      else $error("Flashing began without detection.");
   a_pilot_mode: assert property (@(posedge MCLK) disable iff (SRST)
      PILOT == (st.mode == rfb_pkg::RFB_FLASH))
      else $error("Pilot does not follow activity.");
   a_never_both_first: assert property (@(posedge MCLK) disable iff (SRST)
      (st.step < 4'h8) |-> !(LAMP_LEFT && LAMP_RIGHT))
      else $error("Both lights on in early phases.");
   a_both_step: assert property (@(posedge MCLK) disable iff (SRST)
      (PILOT && st.step == 4'h8) |-> LAMP_LEFT && LAMP_RIGHT)
      else $error("Both-on phase wrong.");
   a_tail_dark: assert property (@(posedge MCLK) disable iff (SRST)
      (st.step == `RFB_LAST_STEP) |-> !LAMP_LEFT && !LAMP_RIGHT && st.sub < 3'h5)
      else $error("Tail phase wrong.");
   a_dim_night: assert property (@(posedge MCLK) disable iff (SRST)
      NIGHT |=> DIM)
      else $error("Dim not asserted at night.");
   a_retrigger: assert property (@(posedge MCLK) disable iff (SRST)
      (PILOT && detect && !PEER_STOP) |=> PILOT && st.remain == $past(ACTIVE_TICKS))
      else $error("Detection did not restart period.");
   a_peer_stop: assert property (@(posedge MCLK) disable iff (SRST)
      (PILOT && PEER_STOP) |=> !PILOT && !LAMP_LEFT)
      else $error("Peer stop ignored.");

   // Start and stop pulses tell the peers exactly when this unit changes activity on its own; changes caused by a peer pulse are not echoed.
   a_local_start: assert property (@(posedge MCLK) disable iff (SRST)
      ($rose(PILOT) && !$past(PEER_START)) |-> SYNC_START)
      else $error("Local start not announced to peers.");
   a_start_only: assert property (@(posedge MCLK) disable iff (SRST)
      SYNC_START |-> $rose(PILOT))
      else $error("Start pulse without a start.");
   a_start_single: assert property (@(posedge MCLK) disable iff (SRST)
      SYNC_START |=> !SYNC_START)
      else $error("Start pulse longer than one cycle.");
   a_peer_start_ack: assert property (@(posedge MCLK) disable iff (SRST)
      (!PILOT && PEER_START) |=> PILOT && !SYNC_START)
      else $error("Peer start not followed.");
   a_local_stop: assert property (@(posedge MCLK) disable iff (SRST)
      ($fell(PILOT) && !$past(PEER_STOP)) |-> SYNC_STOP)
      else $error("Local stop not announced to peers.");
   a_stop_only: assert property (@(posedge MCLK) disable iff (SRST)
      SYNC_STOP |-> $fell(PILOT))
      else $error("Stop pulse without a stop.");
   a_peer_stop_quiet: assert property (@(posedge MCLK) disable iff (SRST)
      (PILOT && PEER_STOP) |=> !SYNC_STOP)
      else $error("Peer stop echoed back.");

   // The active period counts down on ticks only and reloads on every detection.
   a_idle_restart: assert property (@(posedge MCLK) disable iff (SRST)
      (!PILOT && detect) |=> PILOT && st.remain == $past(ACTIVE_TICKS))
      else $error("Detection after the end did not restart.");
   a_remain_down: assert property (@(posedge MCLK) disable iff (SRST)
      (PILOT && $past(PILOT) && !$past(detect) && $past(tick) && $past(st.remain) != '0) |-> st.remain == $past(st.remain) - 1'b1)
      else $error("Active period did not count down.");
   // Outside ticks the period only moves when a detection reloads it.
   a_remain_hold: assert property (@(posedge MCLK) disable iff (SRST)
      (PILOT && $past(PILOT) && !$past(detect) && !$past(tick)) |-> $stable(st.remain))
      else $error("Active period moved between ticks.");
   a_hold_active: assert property (@(posedge MCLK) disable iff (SRST)
      (PILOT && (st.remain != '0 || detect) && !PEER_STOP) |=> PILOT)
      else $error("Flashing stopped early.");
   // A stop needs either a peer stop or an expired period with no detection.
   a_stop_cause: assert property (@(posedge MCLK) disable iff (SRST)
      $fell(PILOT) |-> $past(PEER_STOP) || ($past(st.remain) == '0 && !$past(detect)))
      else $error("Flashing stopped without cause.");
   a_stop_dark: assert property (@(posedge MCLK) disable iff (SRST)
      $fell(PILOT) |-> !LAMP_LEFT && !LAMP_RIGHT)
      else $error("Light left on at stop.");

   // The phase counter walks the pattern one tick at a time.
   a_first_left: assert property (@(posedge MCLK) disable iff (SRST)
      $rose(PILOT) |-> LAMP_LEFT && !LAMP_RIGHT)
      else $error("Pattern did not open with the left light.");
   a_left_phase: assert property (@(posedge MCLK) disable iff (SRST)
      (PILOT && (st.step == 4'h0 || st.step == 4'h4)) |-> LAMP_LEFT && !LAMP_RIGHT)
      else $error("Left phase wrong.");
   a_right_phase: assert property (@(posedge MCLK) disable iff (SRST)
      (PILOT && (st.step == 4'h2 || st.step == 4'h6 || st.step == 4'ha)) |-> !LAMP_LEFT && LAMP_RIGHT)
      else $error("Right phase wrong.");
   a_dark_phase: assert property (@(posedge MCLK) disable iff (SRST)
      (PILOT && st.step[0]) |-> !LAMP_LEFT && !LAMP_RIGHT)
      else $error("Dark phase lit.");
   a_step_range: assert property (@(posedge MCLK) disable iff (SRST)
      st.step <= `RFB_LAST_STEP)
      else $error("Phase counter out of range.");
   a_step_on_tick: assert property (@(posedge MCLK) disable iff (SRST)
      (PILOT && $past(PILOT) && $changed(st.step)) |-> $past(tick))
      else $error("Phase moved without a tick.");
   a_sub_zero: assert property (@(posedge MCLK) disable iff (SRST)
      (st.step != `RFB_LAST_STEP) |-> st.sub == '0)
      else $error("Tail counter running outside the tail.");
   // The pattern wraps only after the long dark tail has run its full five ticks.
   a_tail_wrap: assert property (@(posedge MCLK) disable iff (SRST)
      (PILOT && $past(PILOT) && $past(st.step) == `RFB_LAST_STEP && st.step == 4'h0) |-> $past(st.sub) == `RFB_LAST_TICKS - 1'b1)
      else $error("Tail ended early.");
   // The divider never passes its terminal count.
   a_tick_bound: assert property (@(posedge MCLK) disable iff (SRST)
      st.tick_cnt < CNT_W'(TICK_CYCLES))
      else $error("Tick divider overran.");

   // Brightness follows the photocell with one cycle of delay.
   a_day_bright: assert property (@(posedge MCLK) disable iff (SRST)
      !NIGHT |=> !DIM)
      else $error("Dim asserted by day.");
endmodule : rfb_sequencer

// ---- rfb_peer.sv ----
`timescale 1ns/10ps
module rfb_peer (
   input  wire logic MCLK,        // Clock.
   input  wire logic SYNC_START,  // Start pulse from the unit.
   input  wire logic SYNC_STOP,   // Stop pulse from the unit.
   output logic      active,      // Peer is flashing.
   output int        starts       // Start pulses seen.
);
   initial begin
      active = 1'b0;
      starts = 0;
   end
   always @(posedge MCLK) begin
      if (SYNC_START) begin
         active <= 1'b1;
         starts <= starts + 1;
      end
      if (SYNC_STOP) begin
         active <= 1'b0;
      end
   end
endmodule : rfb_peer

// ---- tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
   logic MCLK = 0, SRST = 1, BUTTON = 0, PASSIVE_EN = 0, PRESENT = 0, PEER_START = 0, PEER_STOP = 0, NIGHT = 0;
   logic [15:0] ACTIVE_TICKS = 16'h0014;
   logic LAMP_LEFT, LAMP_RIGHT, DIM, PILOT, SYNC_START, SYNC_STOP, peer_on;
   int   fail_count = 0, total_checks = 0, starts;
   always #2 MCLK = ~MCLK;
   rfb_sequencer #(.TICK_CYCLES(10)) u_rfb_sequencer (.MCLK(MCLK), .SRST(SRST), .BUTTON(BUTTON),
      .PASSIVE_EN(PASSIVE_EN), .PRESENT(PRESENT), .PEER_START(PEER_START), .PEER_STOP(PEER_STOP),
      .NIGHT(NIGHT), .ACTIVE_TICKS(ACTIVE_TICKS), .LAMP_LEFT(LAMP_LEFT), .LAMP_RIGHT(LAMP_RIGHT),
      .DIM(DIM), .PILOT(PILOT), .SYNC_START(SYNC_START), .SYNC_STOP(SYNC_STOP));
   rfb_peer u_rfb_peer (.MCLK(MCLK), .SYNC_START(SYNC_START), .SYNC_STOP(SYNC_STOP), .active(peer_on),
      .starts(starts));
   task automatic check(input logic [3:0] seen, input logic [3:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wait_n(input int n);
      repeat (n) @(negedge MCLK);
   endtask : wait_n
   // Raises one detection or peer input for exactly one sampling edge.
   task automatic pulse(input int k);
      @(posedge MCLK);
      case (k)
         0: BUTTON <= 1'b1;
         1: PEER_START <= 1'b1;
         default: PEER_STOP <= 1'b1;
      endcase
      @(posedge MCLK);
      {BUTTON, PEER_START, PEER_STOP} <= 3'h0;
   endtask : pulse
   task automatic t_pattern;
      logic [11:0] lm;
      logic [11:0] rm;
      int          s;
      lm = 12'h111;
      rm = 12'h544;
      check({LAMP_LEFT, LAMP_RIGHT, PILOT}, 4'h0);
      pulse(0);
      wait_n(1);
      check(SYNC_START, 4'h1);
      wait_n(4);
      for (int t = 0; t < 17; t++) begin
         s = (t % 16 > 11) ? 11 : t % 16;
         check({LAMP_LEFT, LAMP_RIGHT}, {lm[s], rm[s]});
         wait_n(10);
      end
      check({PILOT, peer_on}, 4'h3);
      wait_n(27);
      check({SYNC_STOP, PILOT}, 4'h2);
      wait_n(33);
      check({PILOT, LAMP_LEFT, LAMP_RIGHT, peer_on}, 4'h0);
   endtask : t_pattern
   task automatic t_retrigger;
      pulse(0);
      wait_n(150);
      pulse(0);
      wait_n(150);
      check(PILOT, 4'h1);
      wait_n(100);
      check(PILOT, 4'h0);
   endtask : t_retrigger
   task automatic t_peer;
      pulse(1);
      wait_n(3);
      check({PILOT, starts[2:0]}, 4'ha);
      pulse(2);
      wait_n(3);
      check(PILOT, 4'h0);
   endtask : t_peer
   task automatic t_passive_dim;
      @(posedge MCLK);
      {PASSIVE_EN, PRESENT, NIGHT} <= 3'h7;
      ACTIVE_TICKS <= 16'h0002;
      wait_n(100);
      check({PILOT, DIM}, 4'h3);
      @(posedge MCLK);
      {PRESENT, NIGHT} <= 2'h0;
      wait_n(40);
      check({PILOT, DIM}, 4'h0);
   endtask : t_passive_dim
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   initial begin
      repeat (16) @(posedge MCLK);
      SRST <= 1'b0;
      wait_n(20);
      t_pattern();
      t_retrigger();
      t_peer();
      t_passive_dim();
      test_done();
   end
   initial begin
      repeat (5000) @(posedge MCLK);
      fail_count++;
      test_done();
   end
endmodule : tb_top
